/* File: logic/hsi_pkg.sv */
// constants, modes and reset values of the host serial link
// assumes a single 40 MHz core clock drives every user of this package
package hsi_pkg;
  // ==========================================================
  // clock and baud figures
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BAUD_MAX_BPS = 6_000_000;
  localparam int unsigned BAUD_DEF_BPS = 115_200;
  localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF_BPS);
  // fastest rate rounds the bit time up to whole cycles
  localparam logic [15:0] DIV_MIN = 16'((CLK_HZ + BAUD_MAX_BPS - 1) / BAUD_MAX_BPS);
  // ==========================================================
  // buffering
  localparam int unsigned FIFO_W = 9;
  localparam int unsigned FIFO_D = 16;
  localparam int unsigned RTS_MARGIN = 3;
  localparam logic [7:0] SPI_IDLE_BYTE = 8'h00;
  // ==========================================================
  // modes and reset values
  typedef enum logic [1:0] {HSI_UART, HSI_SPI, HSI_USB} hsi_host_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} hsi_par_t;
  typedef enum logic [2:0] {U_IDLE, U_START, U_DATA, U_PAR, U_STOP} hsi_ust_t;
  localparam hsi_host_t HOST_DEF = HSI_UART;
  localparam hsi_par_t PAR_DEF = PAR_NONE;
  localparam logic NINE_DEF = 1'b0;
  localparam logic TWO_STOP_DEF = 1'b0;
  localparam logic FLOW_DEF = 1'b1;
  localparam logic CPOL_DEF = 1'b0;
  localparam logic CPHA_DEF = 1'b0;
endpackage : hsi_pkg

/* File: logic/hsi_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes both sides run on the same clock as the fifo
`timescale 1ns/1ps
module hsi_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned D = 16
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(D):0] level_o
);
  localparam int unsigned AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hsi_fifo_st_t;
  hsi_fifo_st_t q, d;
  logic [W-1:0] mem [D];
  logic push, pop;

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    d = q;
    if (push) begin
      d.wp = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage carries no reset; only the pointers and the count need a defined value
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[q.wp] <= in_data_i;
    end
  end

  assign in_ready_o = (q.cnt != (AW + 1)'(D));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = mem[q.rp];
  assign level_o = q.cnt;
endmodule : hsi_fifo

/* File: logic/hsi_top.sv */
// host serial link: uart with rts/cts, spi slave with notify, usb select flag
// assumes link pins are asynchronous to mclk_i; config and user ports are not
// Function
// - exactly one host interface carries traffic
// - uart is the host interface after reset
// - baud 9600 to 6M, default 115200
// - spi stays disabled until configured
// - module is spi slave only
// - spi msb first, configurable cpol/cpha
// - notify output high while data waits, with spi selected as host
// - usb disabled by default, cdc device; the module only drives the usb_en_o flag
`timescale 1ns/1ps
module hsi_top import hsi_pkg::*; #(
  parameter int unsigned BAUD_MIN_BPS = 9600
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic cfg_load_i,
  input wire hsi_pkg::hsi_host_t cfg_host_i,
  input wire logic [15:0] cfg_baud_div_i,
  input wire logic cfg_nine_i,
  input wire hsi_pkg::hsi_par_t cfg_par_i,
  input wire logic cfg_two_stop_i,
  input wire logic cfg_flow_i,
  input wire logic cfg_cpol_i,
  input wire logic cfg_cpha_i,
  input wire logic tx_valid_i,
  input wire logic [hsi_pkg::FIFO_W-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [hsi_pkg::FIFO_W-1:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic uart_rxd_i,
  output logic uart_txd_o,
  input wire logic uart_cts_pad_i,
  output logic uart_rts_pad_o,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic host_notify_output_o,
  output logic usb_en_o,
  output hsi_pkg::hsi_host_t host_sel_o,
  output logic parity_err_o,
  output logic frame_err_o,
  output logic overrun_o
);
  import hsi_pkg::*;
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_MIN_BPS);
  localparam logic [4:0] RTS_LVL = 5'(FIFO_D - RTS_MARGIN);

  typedef struct packed {
    hsi_host_t host;
    logic [15:0] div;
    logic nine, two, flow, cpol, cpha;
    hsi_par_t par;
    logic rxd_s1, rxd_s2, cts_s1, cts_s2, mosi_s1, mosi_s2;
    logic sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, cs_s3;
    hsi_ust_t ts;
    logic [15:0] tcnt;
    logic [3:0] tbit;
    logic [8:0] tsh;
    logic tpar, txd;
    hsi_ust_t rs;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rpar, rbad;
    logic [2:0] sbit;
    logic [7:0] srx, stx;
    logic miso, miso_oe, notify, rts, usb, perr, ferr, ovr;
  } hsi_st_t;
  hsi_st_t q, d;

  logic tx_v, tx_pop, rx_rdy, rx_push, spi_load;
  logic [8:0] tx_dat, rx_pdata, nsh;
  logic [4:0] rx_lvl;
  logic ttick, rtick, lead, trail, smp, shf;
  logic [7:0] sld;

  function automatic logic par_bit(logic [8:0] v, logic nine, hsi_par_t p);
    logic x;
    x = nine ? ^v : ^v[7:0];
    return (p == PAR_ODD) ? ~x : x;
  endfunction : par_bit

  // ==========================================================
  // buffers: link to user and user to link
  hsi_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rx_fifo (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .in_valid_i(rx_push), .in_data_i(rx_pdata), .in_ready_o(rx_rdy),
    .out_valid_o(rx_valid_o), .out_data_o(rx_data_o), .out_ready_i(rx_ready_i),
    .level_o(rx_lvl)
  );
  hsi_fifo #(.W(FIFO_W), .D(FIFO_D)) u_tx_fifo (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .in_valid_i(tx_valid_i), .in_data_i(tx_data_i), .in_ready_o(tx_ready_o),
    .out_valid_o(tx_v), .out_data_o(tx_dat), .out_ready_i(tx_pop),
    .level_o()
  );

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pdata = q.rsh;
    spi_load = 1'b0;
    sld = tx_v ? tx_dat[7:0] : SPI_IDLE_BYTE;
    nsh = {q.rxd_s2, q.rsh[8:1]};
    d.perr = 1'b0;
    d.ferr = 1'b0;
    d.ovr = 1'b0;
    {d.rxd_s1, d.rxd_s2, d.cts_s1, d.cts_s2} = {uart_rxd_i, q.rxd_s1, uart_cts_pad_i, q.cts_s1};
    {d.mosi_s1, d.mosi_s2} = {spi_mosi_i, q.mosi_s1};
    {d.sck_s1, d.sck_s2, d.sck_s3} = {spi_sck_i, q.sck_s1, q.sck_s2};
    {d.cs_s1, d.cs_s2, d.cs_s3} = {spi_cs_n_i, q.cs_s1, q.cs_s2};
    if (cfg_load_i) begin
      d.host = cfg_host_i;
      // out-of-range divisors are pulled to the nearest legal rate
      d.div = (cfg_baud_div_i < DIV_MIN) ? DIV_MIN :
              (cfg_baud_div_i > DIV_MAX) ? DIV_MAX : cfg_baud_div_i;
      {d.nine, d.par, d.two, d.flow} = {cfg_nine_i, cfg_par_i, cfg_two_stop_i, cfg_flow_i};
      {d.cpol, d.cpha} = {cfg_cpol_i, cfg_cpha_i};
    end

    // uart transmitter
    ttick = (q.tcnt == '0);
    d.tcnt = ttick ? q.div - 16'h1 : q.tcnt - 16'h1;
    case (q.ts)
      U_IDLE: begin
        d.txd = 1'b1;
        // cts is looked at only between frames, so one byte may follow its release
        if (q.host == HSI_UART && tx_v && (!q.flow || !q.cts_s2)) begin
          tx_pop = 1'b1;
          d.tsh = tx_dat;
          d.tpar = par_bit(tx_dat, q.nine, q.par);
          d.ts = U_START;
          d.txd = 1'b0;
          d.tcnt = q.div - 16'h1;
        end
      end
      U_START: begin
        if (ttick) begin
          d.ts = U_DATA;
          d.txd = q.tsh[0];
          d.tsh = q.tsh >> 1;
          d.tbit = '0;
        end
      end
      U_DATA: begin
        if (ttick) begin
          if (q.tbit == (q.nine ? 4'h8 : 4'h7)) begin
            d.ts = (q.par == PAR_NONE) ? U_STOP : U_PAR;
            d.txd = (q.par == PAR_NONE) ? 1'b1 : q.tpar;
            d.tbit = '0;
          end else begin
            d.txd = q.tsh[0];
            d.tsh = q.tsh >> 1;
            d.tbit = q.tbit + 4'h1;
          end
        end
      end
      U_PAR: begin
        if (ttick) begin
          d.ts = U_STOP;
          d.txd = 1'b1;
        end
      end
      default: begin
        if (ttick) begin
          if (q.two && q.tbit == '0) begin
            d.tbit = 4'h1;
          end else begin
            d.ts = U_IDLE;
          end
        end
      end
    endcase

    // uart receiver, sampling mid-bit
    rtick = (q.rcnt == '0);
    d.rcnt = rtick ? q.div - 16'h1 : q.rcnt - 16'h1;
    case (q.rs)
      U_IDLE: begin
        if (q.host == HSI_UART && !q.rxd_s2) begin
          d.rs = U_START;
          d.rcnt = q.div >> 1;
        end
      end
      U_START: begin
        if (rtick) begin
          d.rs = q.rxd_s2 ? U_IDLE : U_DATA; // glitch shorter than half a bit
          {d.rbit, d.rpar, d.rbad} = '0;
        end
      end
      U_DATA: begin
        if (rtick) begin
          d.rpar = q.rpar ^ q.rxd_s2;
          d.rsh = nsh;
          d.rbit = q.rbit + 4'h1;
          if (q.rbit == (q.nine ? 4'h8 : 4'h7)) begin
            d.rsh = q.nine ? nsh : {1'b0, nsh[8:1]};
            d.rs = (q.par == PAR_NONE) ? U_STOP : U_PAR;
          end
        end
      end
      U_PAR: begin
        if (rtick) begin
          d.rbad = ((q.rxd_s2 ^ q.rpar) != (q.par == PAR_ODD));
          d.rs = U_STOP;
        end
      end
      default: begin
        if (rtick) begin
          d.rs = U_IDLE;
          // errored frames are flagged and dropped, never buffered
          d.ferr = !q.rxd_s2;
          d.perr = q.rxd_s2 && q.rbad;
          rx_push = q.rxd_s2 && !q.rbad;
          d.ovr = rx_push && !rx_rdy;
        end
      end
    endcase

    // spi slave, edges found on the synchronised clock
    lead = (q.sck_s2 ^ q.sck_s3) && (q.sck_s2 != q.cpol);
    trail = (q.sck_s2 ^ q.sck_s3) && (q.sck_s2 == q.cpol);
    smp = q.cpha ? trail : lead;
    shf = q.cpha ? lead : trail;
    d.miso_oe = (q.host == HSI_SPI) && !q.cs_s2;
    if (q.host == HSI_SPI && !q.cs_s2) begin
      if (q.cs_s3) begin
        d.sbit = '0;
        spi_load = !q.cpha;
      end else if (smp) begin
        d.srx = {q.srx[6:0], q.mosi_s2};
        d.sbit = q.sbit + 3'h1;
        if (q.sbit == 3'h7) begin
          rx_push = 1'b1;
          rx_pdata = {1'b0, q.srx[6:0], q.mosi_s2};
          d.ovr = !rx_rdy;
        end
      end else if (shf) begin
        if (q.sbit == '0) begin
          spi_load = 1'b1;
        end else begin
          d.stx = {q.stx[6:0], 1'b0};
          d.miso = q.stx[6];
        end
      end
    end
    if (spi_load) begin
      tx_pop = tx_v;
      d.stx = sld;
      d.miso = sld[7];
    end
    d.notify = (q.host == HSI_SPI) && tx_v;
    // keep a margin so bytes already on the wire still fit
    d.rts = (q.host != HSI_UART) || (q.flow && rx_lvl >= RTS_LVL);
    d.usb = (d.host == HSI_USB);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.host <= HOST_DEF;
      q.div <= DIV_DEF;
      {q.nine, q.par, q.two, q.flow} <= {NINE_DEF, PAR_DEF, TWO_STOP_DEF, FLOW_DEF};
      {q.cpol, q.cpha} <= {CPOL_DEF, CPHA_DEF};
      {q.rxd_s1, q.rxd_s2, q.cts_s1, q.cts_s2, q.txd, q.rts} <= 6'h3F;
      {q.cs_s1, q.cs_s2, q.cs_s3} <= 3'h7;
      q.ts <= U_IDLE;
      q.rs <= U_IDLE;
    end else begin
      q <= d;
    end
  end

  assign uart_txd_o = q.txd;
  assign uart_rts_pad_o = q.rts;
  assign spi_miso_o = q.miso;
  assign spi_miso_oe_o = q.miso_oe;
  assign host_notify_output_o = q.notify;
  assign usb_en_o = q.usb;
  assign host_sel_o = q.host;
  assign parity_err_o = q.perr;
  assign frame_err_o = q.ferr;
  assign overrun_o = q.ovr;

  // ==========================================================
  // checks
  logic cfg_seen_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_seen_q <= 1'b0;
    end else if (cfg_load_i) begin
      cfg_seen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_usb_quiet: assert property (usb_en_o |-> uart_txd_o && !spi_miso_oe_o)
    else $error("usb host but another link active");
  a_reset_uart: assert property (!cfg_seen_q |-> host_sel_o == HSI_UART && !usb_en_o)
    else $error("default host is not uart");
  a_baud_range: assert property (q.div >= DIV_MIN && q.div <= DIV_MAX)
    else $error("divisor out of range");
  a_stop_high: assert property (q.ts == U_STOP || q.ts == U_IDLE |-> uart_txd_o)
    else $error("line low in stop or idle");
  a_cts_gate: assert property (q.ts == U_IDLE ##1 q.ts == U_START |->
      !$past(q.flow) || !$past(q.cts_s2))
    else $error("frame started while cts high");
  a_rts_full: assert property (host_sel_o == HSI_UART && q.flow && rx_lvl >= RTS_LVL
      |=> uart_rts_pad_o)
    else $error("rts low with rx fifo nearly full");
  a_spi_off: assert property (spi_miso_oe_o |-> $past(host_sel_o) == HSI_SPI)
    else $error("miso driven with spi not selected");
  a_spi_slave: assert property (spi_cs_n_i [*4] |-> !spi_miso_oe_o)
    else $error("miso driven without chip select");
  a_spi_msb: assert property (spi_load |=> spi_miso_o == $past(sld[7]))
    else $error("msb not presented first");
  a_notify: assert property (host_sel_o == HSI_SPI && tx_v |=> host_notify_output_o)
    else $error("notify low with data pending");
  a_usb_flag: assert property (usb_en_o == (host_sel_o == HSI_USB))
    else $error("usb enable mismatch");
  c_uart_tx: cover property (q.ts == U_STOP ##1 q.ts == U_IDLE);
  c_uart_rx: cover property (rx_push && host_sel_o == HSI_UART);
  c_spi_rx: cover property (rx_push && host_sel_o == HSI_SPI);
  c_par_err: cover property (parity_err_o);
endmodule : hsi_top

/* File: verif/hsi_host_model.sv */
// host partner of the link: uart peer with rts/cts handshake and spi master
// assumes the bench calls one task at a time and keeps config still during traffic
`timescale 1ns/1ps
module hsi_host_model (
  input wire logic [15:0] div_i,
  input wire logic nine_i,
  input wire hsi_pkg::hsi_par_t par_i,
  input wire logic two_stop_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic stall_i,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic rts_i,
  output logic rts_o,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  output logic got_o,
  output logic [9:0] got_data_o
);
  import hsi_pkg::*;
  int bt;
  assign bt = 25 * int'(div_i);
  assign rts_o = stall_i;
  initial begin
    txd_o = 1'b1;
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    got_o = 1'b0;
    got_data_o = '0;
  end
  function automatic logic par_of(input logic [8:0] d);
    return (^(d & {nine_i, 8'hFF})) ^ (par_i == PAR_ODD);
  endfunction : par_of
  // ==========================================================
  // uart receive: never refuses, so bytes sent after a stall still land
  always begin : rx_side
    logic [8:0] d;
    logic ok;
    @(negedge rxd_i);
    d = '0;
    #(bt / 2);
    ok = !rxd_i;
    for (int i = 0; i < 8 + nine_i; i++) begin
      #(bt);
      d[i] = rxd_i;
    end
    if (par_i != PAR_NONE) begin
      #(bt);
      ok &= rxd_i == par_of(d);
    end
    #(bt);
    ok &= rxd_i;
    if (two_stop_i) begin
      #(bt);
      ok &= rxd_i;
    end
    got_data_o = {ok, d};
    got_o = !got_o;
  end
  // ==========================================================
  // uart send, waits while the module asks the host to hold off
  task automatic uart_send(input logic [8:0] d, input logic bad);
    while (rts_i !== 1'b0) #(bt);
    txd_o = 1'b0;
    #(bt);
    for (int i = 0; i < 8 + nine_i; i++) begin
      txd_o = d[i];
      #(bt);
    end
    if (par_i != PAR_NONE) begin
      txd_o = par_of(d) ^ bad;
      #(bt);
    end
    txd_o = 1'b1;
    #(bt * (2 + two_stop_i));
  endtask : uart_send
  // ==========================================================
  // spi master, 200 ns clock; clock stands at its idle level between frames
  task automatic spi_xfer(input logic [7:0] m);
    logic [7:0] s;
    sck_o = cpol_i;
    #(200);
    cs_n_o = 1'b0;
    #(100);
    for (int i = 7; i >= 0; i--) begin
      if (!cpha_i) mosi_o = m[i];
      #(100) sck_o = !sck_o;
      if (cpha_i) mosi_o = m[i];
      else s[i] = miso_i;
      #(100) sck_o = !sck_o;
      if (cpha_i) s[i] = miso_i;
    end
    #(100) cs_n_o = 1'b1;
    mosi_o = !mosi_o;
    got_data_o = {2'b10, s};
    got_o = !got_o;
  endtask : spi_xfer
endmodule : hsi_host_model

/* File: verif/tb_hsi_top.sv */
// self-checking bench of the host serial link with a host partner model
// assumes hsi_pkg, hsi_fifo, hsi_top and hsi_host_model are compiled first
`timescale 1ns/1ps
module tb_hsi_top;
  import hsi_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cfg_load_i = 1'b0;
  hsi_host_t cfg_host_i = HOST_DEF;
  logic [15:0] cfg_baud_div_i = DIV_DEF;
  logic cfg_nine_i = NINE_DEF;
  hsi_par_t cfg_par_i = PAR_DEF;
  logic cfg_two_stop_i = TWO_STOP_DEF;
  logic cfg_flow_i = FLOW_DEF;
  logic cfg_cpol_i = CPOL_DEF;
  logic cfg_cpha_i = CPHA_DEF;
  logic tx_valid_i = 1'b0;
  logic [8:0] tx_data_i = 9'h000;
  logic rx_ready_i = 1'b0;
  logic stall = 1'b0;
  logic hold_rx = 1'b0;
  logic uart_rxd_i, uart_txd_o, uart_cts_pad_i, uart_rts_pad_o, spi_sck_i, spi_cs_n_i;
  logic spi_mosi_i, spi_miso_o, spi_miso_oe_o, host_notify_output_o, usb_en_o, tx_ready_o;
  logic rx_valid_o, parity_err_o, frame_err_o, overrun_o, miso_w, got;
  logic [8:0] rx_data_o, d, er;
  logic [9:0] got_data, el;
  hsi_host_t host_sel_o;
  logic [31:0] lfsr = 32'hF25A;
  logic [15:0] dvs [3] = '{16'h0014, 16'h003E, 16'h0007};
  logic [8:0] exp_rx[$];
  logic [9:0] exp_link[$];
  int err_count, samples_checked, perr, bad, cycles;
  // released miso is pulled high so a silent slave reads as all ones
  assign miso_w = spi_miso_oe_o ? spi_miso_o : 1'b1;
  always #12.5 mclk_i = ~mclk_i;
  // default slowest rate kept so the reset divisor stays inside the legal range
  hsi_top uut (
    .mclk_i, .nrst_i, .cfg_load_i, .cfg_host_i, .cfg_baud_div_i, .cfg_nine_i, .cfg_par_i,
    .cfg_two_stop_i, .cfg_flow_i, .cfg_cpol_i, .cfg_cpha_i, .tx_valid_i, .tx_data_i,
    .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .uart_rxd_i, .uart_txd_o,
    .uart_cts_pad_i, .uart_rts_pad_o, .spi_sck_i, .spi_cs_n_i, .spi_mosi_i, .spi_miso_o,
    .spi_miso_oe_o, .host_notify_output_o, .usb_en_o, .host_sel_o, .parity_err_o,
    .frame_err_o, .overrun_o
  );
  hsi_host_model host (
    .div_i(cfg_baud_div_i), .nine_i(cfg_nine_i), .par_i(cfg_par_i), .two_stop_i(cfg_two_stop_i),
    .cpol_i(cfg_cpol_i), .cpha_i(cfg_cpha_i), .stall_i(stall), .rxd_i(uart_txd_o),
    .txd_o(uart_rxd_i), .rts_i(uart_rts_pad_o), .rts_o(uart_cts_pad_i), .sck_o(spi_sck_i),
    .cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i), .miso_i(miso_w), .got_o(got),
    .got_data_o(got_data)
  );
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // called at a rising edge; valid stays up so back-to-back words need no gap
  task automatic push_tx(input logic [8:0] w);
    tx_data_i <= w;
    tx_valid_i <= 1'b1;
    exp_link.push_back({1'b1, w[8] & cfg_nine_i, w[7:0]});
    @(negedge mclk_i);
    while (tx_ready_o !== 1'b1) @(negedge mclk_i);
    @(posedge mclk_i);
  endtask : push_tx
  task automatic cfg(input hsi_host_t h, input logic [15:0] dv, input logic n,
                     input hsi_par_t p, input logic t, input logic cp, input logic ch);
    @(posedge mclk_i);
    cfg_host_i <= h;
    cfg_par_i <= p;
    {cfg_baud_div_i, cfg_nine_i, cfg_two_stop_i, cfg_cpol_i, cfg_cpha_i} <= {dv, n, t, cp, ch};
    cfg_load_i <= 1'b1;
    @(posedge mclk_i);
    cfg_load_i <= 1'b0;
    @(negedge mclk_i);
    chk("host", host_sel_o, h);
    chk("usb", usb_en_o, h == HSI_USB);
  endtask : cfg
  task automatic wait_idle();
    repeat (8000) if (exp_link.size() + exp_rx.size() != 0) @(posedge mclk_i);
    repeat (20) @(posedge mclk_i);
  endtask : wait_idle
  // ==========================================================
  // watchers: oldest note against each result as it appears
  always @(posedge mclk_i) begin
    lfsr <= lfsr_next(lfsr);
    rx_ready_i <= !hold_rx && lfsr[3];
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      complete_run();
    end
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
      er = exp_rx.size() ? exp_rx.pop_front() : 'x;
      chk("rx", {1'b0, rx_data_o}, {1'b0, er});
    end
    if (parity_err_o === 1'b1) perr++;
    if (frame_err_o === 1'b1 || overrun_o === 1'b1) bad++;
  end
  always @(got) begin
    el = exp_link.size() ? exp_link.pop_front() : 'x;
    chk("link", got_data, el);
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(negedge mclk_i);
    chk("host", host_sel_o, HSI_UART);
    chk("usb", usb_en_o, 1'b0);
    chk("notify", host_notify_output_o, 1'b0);
    // rts holds its reset level until the first edge after release
    @(negedge mclk_i);
    chk("rts", uart_rts_pad_o, 1'b0);
    @(posedge mclk_i);
    push_tx(9'h0A5);
    tx_valid_i <= 1'b0;
    exp_rx.push_back(9'h03C);
    host.uart_send(9'h03C, 1'b0);
    wait_idle();
    stall <= 1'b1;
    cfg(HSI_UART, 16'h0007, 1'b0, PAR_NONE, 1'b0, 1'b0, 1'b0);
    @(posedge mclk_i);
    repeat (16) push_tx(lfsr[8:0]);
    tx_valid_i <= 1'b0;
    @(negedge mclk_i);
    chk("full", tx_ready_o, 1'b0);
    repeat (300) @(posedge mclk_i);
    chk("held", exp_link.size(), 16);
    stall <= 1'b0;
    repeat (2000) if (exp_link.size() > 14) @(posedge mclk_i);
    stall <= 1'b1;
    repeat (400) @(posedge mclk_i);
    chk("stop", exp_link.size() >= 12, 1'b1);
    stall <= 1'b0;
    wait_idle();
    hold_rx <= 1'b1;
    repeat (13) begin
      d = lfsr[8:0];
      exp_rx.push_back({1'b0, d[7:0]});
      host.uart_send(d, 1'b0);
    end
    @(negedge mclk_i);
    chk("rts", uart_rts_pad_o, 1'b1);
    hold_rx <= 1'b0;
    wait_idle();
    for (int k = 0; k < 3; k++) begin
      cfg(HSI_UART, dvs[k], k != 1, hsi_par_t'(k), k != 0, 1'b0, 1'b0);
      @(posedge mclk_i);
      d = lfsr[8:0];
      push_tx(d);
      push_tx(~d);
      tx_valid_i <= 1'b0;
      if (k != 0) host.uart_send(d, 1'b1);
      exp_rx.push_back(d & {cfg_nine_i, 8'hFF});
      host.uart_send(d, 1'b0);
      wait_idle();
    end
    exp_link.push_back(10'h2FF);
    host.spi_xfer(8'h5A);
    wait_idle();
    for (int m = 0; m < 4; m++) begin
      cfg(HSI_SPI, 16'h0007, 1'b0, PAR_NONE, 1'b0, m[1], m[0]);
      @(posedge mclk_i);
      d = lfsr[8:0];
      push_tx(d);
      tx_valid_i <= 1'b0;
      repeat (2) @(negedge mclk_i);
      chk("notify", host_notify_output_o, 1'b1);
      exp_rx.push_back({1'b0, ~d[7:0]});
      host.spi_xfer(~d[7:0]);
      repeat (10) @(negedge mclk_i);
      chk("notify", host_notify_output_o, 1'b0);
      wait_idle();
    end
    cfg(HSI_USB, 16'h0007, 1'b0, PAR_NONE, 1'b0, 1'b0, 1'b0);
    chk("rts", uart_rts_pad_o, 1'b1);
    chk("perr", perr, 2);
    chk("ferr", bad, 0);
    complete_run();
  end
endmodule : tb_hsi_top
